// [adapter_register_slave_port_test.sv]
// Self-checking bench for the adapter register slave port
`timescale 1ns/100ps
module adapter_register_slave_port_test;
  import arsp_pkg::*;
  logic               clock_i;
  logic               nrst_i;
  logic               cmd_valid, addr_perr, data_perr, ds_busy, need_mst;
  logic [3:0]         cmd;
  logic [ARSP_AW-1:0] addr;
  logic [ARSP_DW-1:0] data, rdata;
  logic [2:0]         rsp;
  logic               rstat, err_intr;
  logic [11:0]        rsq;
  logic [31:0]        rdv, d, seed, r;
  logic               rsv, eiv, ctl;
  logic [6:0]         idx;
  logic [31:0]        mem [128];
  int                 fails, n_checks, cyc;

  // ****************************************************************
  // Clock, design, far-side model
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  arsp_port u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .addr_i(addr),
    .addr_perr_i(addr_perr), .data_i(data), .data_perr_i(data_perr),
    .ds_busy_i(ds_busy), .need_master_i(need_mst), .rsp_o(rsp),
    .rdata_o(rdata), .rstat_o(rstat), .err_intr_o(err_intr));
  arsp_bus_master u_mst (.clock_i(clock_i), .rsp_i(rsp),
    .rdata_i(rdata), .rstat_i(rstat), .err_intr_i(err_intr),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd), .addr_o(addr),
    .addr_perr_o(addr_perr), .data_o(data), .data_perr_o(data_perr),
    .ds_busy_o(ds_busy), .need_master_o(need_mst));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [12:0] ent(input logic [6:0] i);
    return {ARSP_MAP_BASE, i, 2'b00};
  endfunction
  // Response pattern, cycle 4 down to cycle 1
  function automatic logic [11:0] exp_rsp(input int k);
    case (k)
      0: return {ARSP_RSP_ACK, ARSP_RSP_NONE, ARSP_RSP_STALL, ARSP_RSP_STALL};
      1: return {ARSP_RSP_NONE, ARSP_RSP_NONE, ARSP_RSP_ACK, ARSP_RSP_STALL};
      2: return {9'h000, ARSP_RSP_NOACK};
      3: return {9'h000, ARSP_RSP_RETRY};
      default: return {9'h000, ARSP_RSP_STALL};
    endcase
  endfunction
  task automatic chk_rsp(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t response got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_x(input logic [3:0] c, input logic [12:0] a,
                      input logic [31:0] v, input logic [4:0] f);
    u_mst.xfer(c, a, v, f, rsq, rdv, rsv, eiv);
  endtask
  task automatic rd(input logic [12:0] a);
    do_x(ARSP_CMD_READ, a, 32'h0000_0000, 5'h00);
    chk_rsp(rsq, exp_rsp(0));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard: whole run needs well under a thousand commands
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst_i = 1'b0;
    seed = 32'h0000_0038;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk_word({rdata[31:5], rsp, rstat, err_intr}, 32'h0000_0000);
    // Every write variant to control, read back through read variants
    for (int c = 4; c <= 7; c++) begin
      d = rnd();
      do_x(c[3:0], ARSP_CTRL_OFS, d, 5'h00);
      chk_rsp(rsq, exp_rsp(1));
      ctl = d[ARSP_CTRL_ERREN];
      do_x(4'(1 + c % 3), ARSP_CTRL_OFS, 32'h0000_0000, 5'h00);
      chk_rsp(rsq, exp_rsp(0));
      chk_word({31'h0, rsv}, 32'h1);
      chk_word({31'h0, rdv[ARSP_CTRL_ERREN]}, {31'h0, ctl});
    end
    // Parity-faulty write must be ignored
    do_x(ARSP_CMD_WRITE, ARSP_CTRL_OFS, {31'h0, ~ctl}, 5'h02);
    chk_rsp(rsq, exp_rsp(4));
    rd(ARSP_CTRL_OFS);
    chk_word({31'h0, rdv[ARSP_CTRL_ERREN]}, {31'h0, ctl});
    $display("test control done");
    // Unused space, read-only status, busy and mastership
    do_x(ARSP_CMD_READ, 13'h0008, 32'h0000_0000, 5'h00);
    chk_rsp(rsq, exp_rsp(2));
    chk_word({31'h0, rsv}, 32'h0);
    do_x(ARSP_CMD_WRITE, 13'h0008, {31'h0, ~ctl}, 5'h00);
    chk_rsp(rsq, exp_rsp(2));
    do_x(ARSP_CMD_WMCI, ARSP_STATUS_OFS, 32'hFFFF_FFFF, 5'h00);
    chk_rsp(rsq, exp_rsp(2));
    rd(ARSP_CTRL_OFS);
    chk_word({31'h0, rdv[ARSP_CTRL_ERREN]}, {31'h0, ctl});
    do_x(ARSP_CMD_READ, ARSP_CTRL_OFS, 32'h0000_0000, 5'h08);
    chk_rsp(rsq, exp_rsp(3));
    do_x(ARSP_CMD_WRITE, ent(7'h05), 32'h0000_0000, 5'h10);
    chk_rsp(rsq, exp_rsp(3));
    $display("test refusals done");
    // Random entry writes, both ends of the table first
    for (int k = 0; k < 32; k++) begin
      r = rnd();
      idx = (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : r[6:0];
      d = rnd();
      do_x(4'h4 + {2'b00, r[9:8]}, ent(idx), d, 5'h00);
      chk_rsp(rsq, exp_rsp(1));
      mem[idx] = d;
      rd(ent(idx));
      chk_word(rdv, d);
    end
    $display("test entries done");
    // Early parity errors end the entry write without a store
    do_x(ARSP_CMD_WRITE, ent(7'h00), ~mem[0], 5'h01);
    chk_rsp(rsq, exp_rsp(4));
    do_x(ARSP_CMD_WRITE, ent(7'h00), ~mem[0], 5'h02);
    chk_rsp(rsq, exp_rsp(4));
    rd(ent(7'h00));
    chk_word(rdv, mem[0]);
    // Late data parity error, error report off then on
    for (int e = 0; e < 2; e++) begin
      do_x(ARSP_CMD_WRITE, ARSP_CTRL_OFS, 32'(e), 5'h00);
      do_x(ARSP_CMD_WRITE, ent(7'h7F), ~mem[127], 5'h04);
      chk_rsp(rsq, exp_rsp(1));
      chk_word({31'h0, eiv}, 32'(e));
      rd(ent(7'h7F));
      chk_word(rdv, mem[127]);
      rd(ARSP_STATUS_OFS);
      chk_word({31'h0, rdv[ARSP_STAT_ABAND]}, 32'h1);
    end
    do_x(ARSP_CMD_WRITE, ARSP_CTRL_OFS, 32'h0000_0002, 5'h00);
    rd(ARSP_STATUS_OFS);
    chk_word({31'h0, rdv[ARSP_STAT_ABAND]}, 32'h0);
    $display("test entry errors done");
    summarize();
  end
endmodule

// [arsp_bus_master.sv]
// Behavioural system-bus master that drives the adapter slave port
`timescale 1ns/100ps
module arsp_bus_master
  import arsp_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic [2:0]         rsp_i,
  input  wire logic [ARSP_DW-1:0] rdata_i,
  input  wire logic               rstat_i,
  input  wire logic               err_intr_i,
  output logic                    cmd_valid_o,
  output logic      [3:0]         cmd_o,
  output logic      [ARSP_AW-1:0] addr_o,
  output logic                    addr_perr_o,
  output logic      [ARSP_DW-1:0] data_o,
  output logic                    data_perr_o,
  output logic                    ds_busy_o,
  output logic                    need_master_o
);
  // Idle bus at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = 4'h0;
    addr_o = 13'h0000;
    addr_perr_o = 1'b0;
    data_o = 32'h0000_0000;
    data_perr_o = 1'b0;
    ds_busy_o = 1'b0;
    need_master_o = 1'b0;
  end

  // One command cycle, then five response cycles are watched.
  // Flags: {need master, busy, late data parity, data parity, addr parity}
  task automatic xfer(input logic [3:0] c, input logic [12:0] a,
                      input logic [31:0] d, input logic [4:0] f,
                      output logic [11:0] rs, output logic [31:0] rd,
                      output logic rv, output logic ei);
    rs = 12'h000;
    rd = 32'h0000_0000;
    rv = 1'b0;
    ei = 1'b0;
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    addr_o <= a;
    data_o <= d;
    addr_perr_o <= f[0];
    data_perr_o <= f[1];
    ds_busy_o <= f[3];
    need_master_o <= f[4];
    // Always runs five cycles after the command, whatever the answer
    for (int i = 1; i <= 5; i++) begin
      @(posedge clock_i);
      if (i == 1) begin
        // Released command, address and data lines carry the inverse so stale values never match
        cmd_valid_o <= 1'b0;
        cmd_o <= ~c;
        addr_o <= ~a;
        data_o <= ~d;
        addr_perr_o <= 1'b0;
        data_perr_o <= f[2];
        ds_busy_o <= 1'b0;
        need_master_o <= 1'b0;
      end else if (i == 3) begin
        data_perr_o <= 1'b0;
      end
      #1;
      if (i <= 4) rs[3*i-1 -: 3] = rsp_i;
      if (rstat_i === 1'b1) begin
        rd = rdata_i;
        rv = 1'b1;
      end
      if (err_intr_i === 1'b1) ei = 1'b1;
    end
  endtask
endmodule

// [arsp_pkg.sv]
// Constants and types shared by the adapter register slave port
package arsp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ARSP_AW = 13;
  localparam int ARSP_DW = 32;
  localparam int ARSP_IW = 7;
  localparam int ARSP_DEPTH = 128;

  // ****************************************************************
  // Register space decode
  // ****************************************************************
  localparam logic [12:0] ARSP_CTRL_OFS   = 13'h0000;
  localparam logic [12:0] ARSP_STATUS_OFS = 13'h0004;
  localparam logic [3:0]  ARSP_MAP_BASE   = 4'h4;    // 0x800 >> 9
  localparam int          ARSP_MAP_LSB    = 9;
  localparam int          ARSP_IDX_LSB    = 2;

  // Field positions and reset values
  localparam int          ARSP_CTRL_ERREN  = 0;
  localparam int          ARSP_CTRL_CLRAB  = 1;
  localparam int          ARSP_STAT_ABAND  = 0;
  localparam int          ARSP_STAT_DSBUSY = 1;
  localparam logic [31:0] ARSP_CTRL_RST    = 32'h0000_0000;

  // ****************************************************************
  // Bus commands and slave responses
  // ****************************************************************
  localparam logic [3:0] ARSP_CMD_READ  = 4'h1;
  localparam logic [3:0] ARSP_CMD_IRCI  = 4'h2;
  localparam logic [3:0] ARSP_CMD_RCI   = 4'h3;
  localparam logic [3:0] ARSP_CMD_WRITE = 4'h4;
  localparam logic [3:0] ARSP_CMD_WMCI  = 4'h7;

  localparam logic [2:0] ARSP_RSP_NONE  = 3'h0;
  localparam logic [2:0] ARSP_RSP_STALL = 3'h1;
  localparam logic [2:0] ARSP_RSP_ACK   = 3'h2;
  localparam logic [2:0] ARSP_RSP_NOACK = 3'h3;
  localparam logic [2:0] ARSP_RSP_RETRY = 3'h4;

  typedef enum logic [3:0] {
    ARSP_IDLE, ARSP_RD_STALL, ARSP_RD_DATA, ARSP_RD_ACK,
    ARSP_WR_STALL, ARSP_MAP_STALL, ARSP_MAP_ACK, ARSP_MAP_WRITE
  } arsp_state_t;

endpackage

// [arsp_port.sv]
// Slave port for the adapter's control registers and translation entries
//
// Operation
// R01: Register read: stall, then data with read status, then acknowledge.
// R02: Read of unused register space answers no-acknowledge, no data.
// R03: Register write: stall, acknowledge only if parity clean, then update.
// R04: Write to unused space answers no-acknowledge, nothing changes.
// R05: Register write with parity error leaves register unchanged, ignored.
// R06: Masked write variants ignore mask bits; all bytes are valid.
// R07: Interlocked and cache read variants act as plain reads.
// R08: Entry write latches address and data, first answer stall.
// R09: Entry write checks address and data parity; error ends it, no write.
// R10: Clean entry write is acknowledged; master treats it as done.
// R11: Data parity error in the acknowledge cycle abandons, may interrupt.
// R12: Latched data onto internal data path bus, address to RAM index.
// R13: Internal data path bus value stored into the addressed entry.
// R14: Busy downstream or needing bus mastership answers retry.
`timescale 1ns/100ps
module arsp_port
  import arsp_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  input  wire logic               cmd_valid_i,
  input  wire logic [3:0]         cmd_i,
  input  wire logic [ARSP_AW-1:0] addr_i,
  input  wire logic               addr_perr_i,
  input  wire logic [ARSP_DW-1:0] data_i,
  input  wire logic               data_perr_i,
  input  wire logic               ds_busy_i,
  input  wire logic               need_master_i,
  output logic      [2:0]         rsp_o,
  output logic      [ARSP_DW-1:0] rdata_o,
  output logic                    rstat_o,
  output logic                    err_intr_o
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic is_map(input logic [ARSP_AW-1:0] a);
    return a[ARSP_AW-1:ARSP_MAP_LSB] == ARSP_MAP_BASE;
  endfunction

  function automatic logic [ARSP_IW-1:0] map_idx(
    input logic [ARSP_AW-1:0] a);
    return a[ARSP_IDX_LSB +: ARSP_IW];
  endfunction

  arsp_ram_if  ram_bus ();
  arsp_state_t state_q;
  logic [2:0]         rsp_q;
  logic [ARSP_DW-1:0] rdata_q;
  logic               rstat_q;
  logic               err_intr_q;
  logic [ARSP_AW-1:0] addr_lat_q;
  logic [ARSP_DW-1:0] data_lat_q;
  logic               aperr_q;
  logic               dperr_q;
  logic [ARSP_DW-1:0] ctrl_q;
  logic               aband_q;
  logic [ARSP_DW-1:0] idp_bus_q;
  logic [ARSP_IW-1:0] ram_idx_q;
  logic               is_rd;
  logic               is_wr;
  logic               reg_hit;
  logic               ctrl_wr;
  logic               abandon;
  logic [ARSP_DW-1:0] status;

  // Masked and cache write codes all fall in the write range
  assign is_rd = cmd_i >= ARSP_CMD_READ && cmd_i <= ARSP_CMD_RCI;   // [R07]
  assign is_wr = cmd_i >= ARSP_CMD_WRITE && cmd_i <= ARSP_CMD_WMCI; // [R06]
  assign reg_hit = addr_i == ARSP_CTRL_OFS || addr_i == ARSP_STATUS_OFS;
  assign ctrl_wr = state_q == ARSP_WR_STALL && !aperr_q && !dperr_q
                   && addr_lat_q == ARSP_CTRL_OFS;
  assign abandon = state_q == ARSP_MAP_ACK && data_perr_i;
  assign status  = {30'h0, ds_busy_i, aband_q};

  // ****************************************************************
  // Transaction sequencer and response
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ARSP_IDLE;
      rsp_q   <= ARSP_RSP_NONE;
    end else begin
      case (state_q)
        ARSP_IDLE: begin
          rsp_q <= ARSP_RSP_NONE;
          if (cmd_valid_i) begin
            if (ds_busy_i || need_master_i) begin
              rsp_q <= ARSP_RSP_RETRY;                    // [R14]
            end else if (is_rd && (reg_hit || is_map(addr_i))) begin
              rsp_q   <= ARSP_RSP_STALL;                  // [R01]
              state_q <= ARSP_RD_STALL;
            end else if (is_wr && addr_i == ARSP_CTRL_OFS) begin
              rsp_q   <= ARSP_RSP_STALL;                  // [R03]
              state_q <= ARSP_WR_STALL;
            end else if (is_wr && is_map(addr_i)) begin
              rsp_q   <= ARSP_RSP_STALL;                  // [R08]
              state_q <= ARSP_MAP_STALL;
            end else begin
              rsp_q <= ARSP_RSP_NOACK;                    // [R02] [R04]
            end
          end
        end
        ARSP_RD_STALL: state_q <= ARSP_RD_DATA;
        // Data cycle carries the read status only, the stall has ended
        ARSP_RD_DATA: begin
          rsp_q   <= ARSP_RSP_NONE;                       // [R01]
          state_q <= ARSP_RD_ACK;
        end
        ARSP_RD_ACK: begin
          rsp_q   <= ARSP_RSP_ACK;                        // [R01]
          state_q <= ARSP_IDLE;
        end
        ARSP_WR_STALL: begin
          // Parity fault drops the write silently
          rsp_q   <= (aperr_q || dperr_q) ? ARSP_RSP_NONE
                                          : ARSP_RSP_ACK; // [R03] [R05]
          state_q <= ARSP_IDLE;
        end
        ARSP_MAP_STALL: begin
          if (aperr_q || dperr_q) begin
            rsp_q   <= ARSP_RSP_NONE;                     // [R09]
            state_q <= ARSP_IDLE;
          end else begin
            rsp_q   <= ARSP_RSP_ACK;                      // [R10]
            state_q <= ARSP_MAP_ACK;
          end
        end
        ARSP_MAP_ACK: begin
          rsp_q   <= ARSP_RSP_NONE;
          state_q <= abandon ? ARSP_IDLE : ARSP_MAP_WRITE; // [R11]
        end
        ARSP_MAP_WRITE: state_q <= ARSP_IDLE;
        default: begin
          rsp_q   <= ARSP_RSP_NONE;
          state_q <= ARSP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Address and data latches
  // ****************************************************************
  // Taken on every accepted command so the check uses the command cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_lat_q <= '0;
      data_lat_q <= '0;
      aperr_q    <= 1'b0;
      dperr_q    <= 1'b0;
    end else if (state_q == ARSP_IDLE && cmd_valid_i) begin
      addr_lat_q <= addr_i;                               // [R08]
      data_lat_q <= data_i;                               // [R08]
      aperr_q    <= addr_perr_i;
      dperr_q    <= data_perr_i;
    end
  end

  // ****************************************************************
  // Control register and abandon flag
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= ARSP_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= data_lat_q;                               // [R03] [R06]
    end
  end

  // A new abandon wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aband_q <= 1'b0;
    end else if (abandon) begin
      aband_q <= 1'b1;
    end else if (ctrl_wr && data_lat_q[ARSP_CTRL_CLRAB]) begin
      aband_q <= 1'b0;
    end
  end

  // Error interrupt only when software enabled reporting
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_intr_q <= 1'b0;
    end else begin
      err_intr_q <= abandon && ctrl_q[ARSP_CTRL_ERREN];  // [R11]
    end
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
      rstat_q <= 1'b0;
    end else if (state_q == ARSP_RD_DATA) begin
      rstat_q <= 1'b1;                                    // [R01]
      if (is_map(addr_lat_q)) begin
        rdata_q <= ram_bus.rdata;
      end else if (addr_lat_q == ARSP_CTRL_OFS) begin
        rdata_q <= ctrl_q;
      end else begin
        rdata_q <= status;
      end
    end else begin
      rdata_q <= '0;                                      // [R02]
      rstat_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Internal data path bus and RAM access
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idp_bus_q <= '0;
      ram_idx_q <= '0;
    end else if (state_q == ARSP_MAP_ACK && !data_perr_i) begin
      idp_bus_q <= data_lat_q;                            // [R12]
      ram_idx_q <= map_idx(addr_lat_q);                   // [R12]
    end
  end

  assign ram_bus.wr_en = state_q == ARSP_MAP_WRITE;       // [R13]
  assign ram_bus.rd_en = state_q == ARSP_RD_STALL;
  assign ram_bus.wdata = idp_bus_q;                       // [R13]
  assign ram_bus.addr  = ram_bus.wr_en ? ram_idx_q : map_idx(addr_lat_q);

  arsp_ram u_ram (
    .clock_i (clock_i),
    .bus     (ram_bus.ram)
  );

  assign rsp_o      = rsp_q;
  assign rdata_o    = rdata_q;
  assign rstat_o    = rstat_q;
  assign err_intr_o = err_intr_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_read_sequence: assert property (                      // [R01]
    state_q == ARSP_IDLE && cmd_valid_i && !ds_busy_i && !need_master_i
    && is_rd && reg_hit
    |=> rsp_o == ARSP_RSP_STALL ##1 rsp_o == ARSP_RSP_STALL
        ##1 (rstat_o && rsp_o == ARSP_RSP_NONE)
        ##1 (rsp_o == ARSP_RSP_ACK && !rstat_o))
    else $error("register read sequence broken");
  a_read_noack: assert property (                         // [R02]
    state_q == ARSP_IDLE && cmd_valid_i && !ds_busy_i && !need_master_i
    && is_rd && !reg_hit && !is_map(addr_i)
    |=> rsp_o == ARSP_RSP_NOACK && !rstat_o && rdata_o == '0)
    else $error("unused read not refused");
  a_write_ack: assert property (                          // [R03]
    state_q == ARSP_WR_STALL && !aperr_q && !dperr_q
    |=> rsp_o == ARSP_RSP_ACK && ctrl_q == $past(data_lat_q))
    else $error("clean register write not applied");
  a_write_noack: assert property (                        // [R04]
    state_q == ARSP_IDLE && cmd_valid_i && !ds_busy_i && !need_master_i
    && is_wr && !is_map(addr_i) && addr_i != ARSP_CTRL_OFS
    |=> rsp_o == ARSP_RSP_NOACK && $stable(ctrl_q) && state_q == ARSP_IDLE)
    else $error("unused write not refused");
  a_write_perr: assert property (                         // [R05]
    state_q == ARSP_WR_STALL && (aperr_q || dperr_q)
    |=> $stable(ctrl_q) && rsp_o == ARSP_RSP_NONE)
    else $error("faulty register write changed state");
  a_map_perr: assert property (                           // [R09]
    state_q == ARSP_MAP_STALL && (aperr_q || dperr_q)
    |=> state_q == ARSP_IDLE [*2] ##0 !ram_bus.wr_en)
    else $error("faulty entry write not ended");
  a_map_ack_write: assert property (                      // [R10]
    state_q == ARSP_MAP_STALL && !aperr_q && !dperr_q
    |=> rsp_o == ARSP_RSP_ACK && state_q == ARSP_MAP_ACK
        ##1 rsp_o == ARSP_RSP_NONE)
    else $error("clean entry write not acknowledged");
  a_map_abandon: assert property (                        // [R11]
    state_q == ARSP_MAP_ACK && data_perr_i
    |=> !ram_bus.wr_en && err_intr_o == ctrl_q[ARSP_CTRL_ERREN] && aband_q)
    else $error("entry write not abandoned on late parity error");
  a_map_store: assert property (                          // [R12]
    state_q == ARSP_MAP_ACK && !data_perr_i
    |=> ram_bus.wr_en && ram_bus.wdata == $past(data_lat_q)
        && ram_bus.addr == map_idx($past(addr_lat_q)))
    else $error("entry write data or index wrong");
  a_busy_retry: assert property (                         // [R14]
    state_q == ARSP_IDLE && cmd_valid_i && (ds_busy_i || need_master_i)
    |=> rsp_o == ARSP_RSP_RETRY && state_q == ARSP_IDLE)
    else $error("busy command not retried");

  c_reg_read: cover property (
    state_q == ARSP_RD_ACK ##1 rsp_o == ARSP_RSP_ACK);
  c_map_write: cover property (state_q == ARSP_MAP_WRITE);
  c_map_abandon: cover property (abandon);
  c_retry: cover property (rsp_o == ARSP_RSP_RETRY);

endmodule

// [arsp_ram.sv]
// Translation entry RAM with registered read data
`timescale 1ns/100ps
module arsp_ram
  import arsp_pkg::*;
(
  input  wire logic clock_i,
  arsp_ram_if.ram   bus
);

  logic [ARSP_DW-1:0] mem_q [ARSP_DEPTH];
  logic [ARSP_DW-1:0] rdata_q;

  // Write port, no reset so the array maps onto RAM
  always_ff @(posedge clock_i) begin
    if (bus.wr_en) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // Read port, data one cycle after the enable
  always_ff @(posedge clock_i) begin
    if (bus.rd_en) begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;

endmodule

// [arsp_ram_if.sv]
// Carrier between the port logic and the translation entry RAM
`timescale 1ns/100ps
interface arsp_ram_if;
  import arsp_pkg::*;
  logic               wr_en;
  logic               rd_en;
  logic [ARSP_IW-1:0] addr;
  logic [ARSP_DW-1:0] wdata;
  logic [ARSP_DW-1:0] rdata;
  modport port (output wr_en, rd_en, addr, wdata, input rdata);
  modport ram  (input wr_en, rd_en, addr, wdata, output rdata);
endinterface
